// [include/psl_pkg.sv]
// Operation
// (R1) rmii valid pin: crs_dv or rx_dv
// (R2) fast link strap presets control three bits
// (R3) auto crossover is inverted disable strap
// (R4) interface select: mii or rmii
// (R5) rmii clock role: master or slave
// (R6) two strap bits derive advertised abilities
// (R7) autoneg enable is inverted disable strap
// (R8) normal led follows source with polarity
// (R9) forced led takes drive value, polarity applied
// (R10) crc gate suppresses bad crc wake indications
// (R11) level indication held until zero written
// (R12) pulse width 8/16/32/64 fast cycles
// (R13) indication select: pulse or level
// (R14) wake enable activates wake detection
// (R15) secure enable requires matching password
// (R16) wake packet enable raises interrupt
// (R17) enabling wake selects wake interrupt source
// (R18) straps latched after reset release
package psl_pkg;

   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_STRAP = 12'h468;
   localparam logic [11:0] IDX_LED = 12'h469;
   localparam logic [11:0] IDX_WAKE = 12'h4A0;
   localparam logic [11:0] IDX_IRQ_STATUS = 12'h4F0;
   localparam logic [11:0] IDX_IRQ_MASK = 12'h4F1;
   localparam logic [11:0] IDX_INT_SOURCE = 12'h4F2;
   localparam int ADR_LSB = 2;

   // strap capture fields
   localparam int ST_VALID_SEL = 12;
   localparam int ST_FAST_LINK = 8;
   localparam int ST_CROSSOVER = 7;
   localparam int ST_RMII_MODE = 4;
   localparam int ST_CLOCK_ROLE = 3;
   localparam int ST_AN_HI = 2;
   localparam int ST_AN_LO = 1;
   localparam int ST_AN_EN = 0;
   localparam logic [15:0] STRAP_RESET = 16'h0087;

   // led override fields
   localparam int LD_POL2 = 6;
   localparam int LD_VAL2 = 5;
   localparam int LD_EN2 = 4;
   localparam int LD_POL1 = 2;
   localparam int LD_VAL1 = 1;
   localparam int LD_EN1 = 0;
   localparam logic [15:0] LED_RESET = 16'h0040;
   localparam logic [15:0] LED_WMASK = 16'h0077;

   // wake filter fields
   localparam int WK_CRC_GATE = 12;
   localparam int WK_LVL_CLR = 11;
   localparam int WK_WIDTH_HI = 10;
   localparam int WK_WIDTH_LO = 9;
   localparam int WK_IND_SEL = 8;
   localparam int WK_ENABLE = 7;
   localparam int WK_BIT_MASK = 6;
   localparam int WK_SECURE = 5;
   localparam int WK_PKT_EN = 0;
   localparam logic [15:0] WAKE_RESET = 16'h1081;
   localparam logic [15:0] WAKE_WMASK = 16'h17E1;

   // interrupt status bits
   localparam int IRQ_PACKET = 0;
   localparam int IRQ_PATTERN = 1;
   localparam int IRQ_WIDTH = 2;

   // fast link presets, bit 4 stands for control register three bit 10
   localparam logic [4:0] FLD_OFF = 5'h00;
   localparam logic [4:0] FLD_ON = 5'h1A;

   // wake pulse width, figures in cycles of the fast clock
   localparam int CLK_PERIOD_PS = 50000;
   localparam int FAST_PERIOD_PS = 8000;
   localparam int PULSE_FAST_0 = 8;
   localparam int PULSE_FAST_1 = 16;
   localparam int PULSE_FAST_2 = 32;
   localparam int PULSE_FAST_3 = 64;
   localparam logic [3:0] PULSE_LEN_0 =
      4'((PULSE_FAST_0 * FAST_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] PULSE_LEN_1 =
      4'((PULSE_FAST_1 * FAST_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] PULSE_LEN_2 =
      4'((PULSE_FAST_2 * FAST_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [3:0] PULSE_LEN_3 =
      4'((PULSE_FAST_3 * FAST_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

   localparam logic [1:0] SETTLE_DONE = 2'h3;

   typedef enum logic [1:0] {
      WI_IDLE,
      WI_PULSE,
      WI_LEVEL
   } psl_wake_ind_e;

endpackage

// [rtl/psl_config.sv]
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
module psl_config (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [15:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic strap_valid_sel_in,
   input wire logic strap_fast_link_in,
   input wire logic strap_crossover_disable_in,
   input wire logic strap_rmii_mode_in,
   input wire logic strap_rmii_slave_in,
   input wire logic strap_an_hi_in,
   input wire logic strap_an_lo_in,
   input wire logic strap_autoneg_disable_in,
   input wire logic crs_dv_in,
   input wire logic rx_dv_in,
   input wire logic [1:0] led_source_in,
   input wire logic wake_packet_in,
   input wire logic pattern_match_in,
   input wire logic bad_crc_in,
   input wire logic password_ok_in,
   output logic rx_valid_pin_out,
   output logic rmii_mode_out,
   output logic rmii_slave_out,
   output logic [4:0] fld_preset_out,
   output logic auto_crossover_out,
   output logic [3:0] advert_ability_out,
   output logic autoneg_enable_out,
   output logic [1:0] led_out,
   output logic wake_detect_out,
   output logic secure_check_out,
   output logic bit_mask_out,
   output logic wake_pin_out,
   output logic wake_int_source_out,
   output logic irq_out
);

   localparam int NSTRAP = 8;
   localparam int IRQ_W = psl_pkg::IRQ_WIDTH;

   function automatic logic reg_hit(input logic [15:0] adr, input logic [11:0] idx);
      reg_hit = (adr[15:psl_pkg::ADR_LSB] == {2'h0, idx});
   endfunction

   function automatic logic [3:0] pulse_len(input logic [1:0] code);
      unique case (code)
         2'h0: pulse_len = psl_pkg::PULSE_LEN_0;
         2'h1: pulse_len = psl_pkg::PULSE_LEN_1;
         2'h2: pulse_len = psl_pkg::PULSE_LEN_2;
         2'h3: pulse_len = psl_pkg::PULSE_LEN_3;
      endcase
   endfunction

   // ability pattern, bits 8..5 of the advertisement register
   function automatic logic [3:0] advert_map(input logic hi, input logic lo);
      unique case ({hi, lo})
         2'h0: advert_map = 4'h1;
         2'h1: advert_map = 4'h3;
         2'h2: advert_map = 4'h5;
         2'h3: advert_map = 4'hF;
      endcase
   endfunction

   // bus access
   logic req;
   logic wr_fire;
   logic lo_lane;
   logic hi_lane;
   logic [15:0] wmask_lanes;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [15:0] rdata_d;

   // straps
   logic [NSTRAP-1:0] strap_raw;
   logic [NSTRAP-1:0] sync1_q;
   logic [NSTRAP-1:0] sync2_q;
   logic [NSTRAP-1:0] sync3_q;
   logic [1:0] settle_q;
   logic captured_q;
   logic [15:0] strap_q;

   // configuration
   logic [15:0] led_q;
   logic [15:0] wake_q;
   logic [IRQ_W-1:0] irq_status_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic int_source_q;

   // wake indication
   psl_pkg::psl_wake_ind_e wind_q;
   logic [3:0] pulse_cnt_q;
   logic crc_ok;
   logic pkt_ok;
   logic pat_ok;
   logic wake_event;
   logic [IRQ_W-1:0] irq_set;
   logic lvl_clear;

   assign req = wb_cyc_in & wb_stb_in;
   // writes land on the edge where the master samples ack
   assign wr_fire = req & wb_we_in & ack_q;
   assign lo_lane = wb_sel_in[0];
   assign hi_lane = wb_sel_in[1];
   assign wmask_lanes = {{8{hi_lane}}, {8{lo_lane}}};

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   always_comb begin
      rdata_d = 16'h0000;
      if (reg_hit(wb_adr_in, psl_pkg::IDX_STRAP)) begin
         rdata_d = strap_q;
      end else if (reg_hit(wb_adr_in, psl_pkg::IDX_LED)) begin
         rdata_d = led_q;
      end else if (reg_hit(wb_adr_in, psl_pkg::IDX_WAKE)) begin
         rdata_d = wake_q;
         rdata_d[psl_pkg::WK_LVL_CLR] = (wind_q == psl_pkg::WI_LEVEL);
      end else if (reg_hit(wb_adr_in, psl_pkg::IDX_IRQ_STATUS)) begin
         rdata_d = {{(16-IRQ_W){1'b0}}, irq_status_q};
      end else if (reg_hit(wb_adr_in, psl_pkg::IDX_IRQ_MASK)) begin
         rdata_d = {{(16-IRQ_W){1'b0}}, irq_mask_q};
      end else if (reg_hit(wb_adr_in, psl_pkg::IDX_INT_SOURCE)) begin
         rdata_d = {15'h0000, int_source_q};
      end
   end

   // unmapped addresses still ack, reading zero
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_q <= 32'h00000000;
      end else if (req & ~ack_q & ~wb_we_in) begin
         rdata_q <= {16'h0000, rdata_d};
      end else begin
         rdata_q <= 32'h00000000;
      end
   end

   assign wb_ack_out = ack_q;
   assign wb_dat_out = rdata_q;

   // straps pass three stages; only the second reads the first
   assign strap_raw = {strap_valid_sel_in, strap_fast_link_in, strap_crossover_disable_in,
                       strap_rmii_mode_in, strap_rmii_slave_in, strap_an_hi_in,
                       strap_an_lo_in, strap_autoneg_disable_in};

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
      end else begin
         sync1_q <= strap_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         settle_q <= 2'h0;
      end else if (settle_q != psl_pkg::SETTLE_DONE) begin
         settle_q <= settle_q + 2'h1;
      end
   end

   // captured once per reset, then frozen
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         strap_q <= psl_pkg::STRAP_RESET;
         captured_q <= 1'b0;
      end else if (!captured_q && settle_q == psl_pkg::SETTLE_DONE && sync2_q == sync3_q) begin // R18
         captured_q <= 1'b1;
         strap_q[psl_pkg::ST_VALID_SEL] <= sync3_q[7];
         strap_q[psl_pkg::ST_FAST_LINK] <= sync3_q[6];
         strap_q[psl_pkg::ST_CROSSOVER] <= ~sync3_q[5]; // R3
         strap_q[psl_pkg::ST_RMII_MODE] <= sync3_q[4];
         strap_q[psl_pkg::ST_CLOCK_ROLE] <= sync3_q[3];
         strap_q[psl_pkg::ST_AN_HI] <= sync3_q[2];
         strap_q[psl_pkg::ST_AN_LO] <= sync3_q[1];
         strap_q[psl_pkg::ST_AN_EN] <= ~sync3_q[0]; // R7
      end
   end

   // strap driven outputs
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         rx_valid_pin_out <= 1'b0;
         rmii_mode_out <= 1'b0;
         rmii_slave_out <= 1'b0;
         fld_preset_out <= psl_pkg::FLD_OFF;
         auto_crossover_out <= 1'b1;
         advert_ability_out <= 4'hF;
         autoneg_enable_out <= 1'b1;
      end else begin
         // mii mode always carries rx_dv
         if (strap_q[psl_pkg::ST_RMII_MODE] && !strap_q[psl_pkg::ST_VALID_SEL]) begin // R1
            rx_valid_pin_out <= crs_dv_in;
         end else begin
            rx_valid_pin_out <= rx_dv_in;
         end
         rmii_mode_out <= strap_q[psl_pkg::ST_RMII_MODE]; // R4
         rmii_slave_out <= strap_q[psl_pkg::ST_CLOCK_ROLE]; // R5
         fld_preset_out <= strap_q[psl_pkg::ST_FAST_LINK] ? psl_pkg::FLD_ON : psl_pkg::FLD_OFF; // R2
         auto_crossover_out <= strap_q[psl_pkg::ST_CROSSOVER]; // R3
         advert_ability_out <= advert_map(strap_q[psl_pkg::ST_AN_HI],
                                          strap_q[psl_pkg::ST_AN_LO]); // R6
         autoneg_enable_out <= strap_q[psl_pkg::ST_AN_EN]; // R7
      end
   end

   // led override register
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         led_q <= psl_pkg::LED_RESET;
      end else if (wr_fire && reg_hit(wb_adr_in, psl_pkg::IDX_LED)) begin
         led_q <= (led_q & ~(psl_pkg::LED_WMASK & wmask_lanes)) |
                  (wb_dat_in[15:0] & psl_pkg::LED_WMASK & wmask_lanes);
      end
   end

   logic [1:0] led_pol;
   logic [1:0] led_val;
   logic [1:0] led_en;
   assign led_pol = {led_q[psl_pkg::LD_POL2], led_q[psl_pkg::LD_POL1]};
   assign led_val = {led_q[psl_pkg::LD_VAL2], led_q[psl_pkg::LD_VAL1]};
   assign led_en = {led_q[psl_pkg::LD_EN2], led_q[psl_pkg::LD_EN1]};

   for (genvar i = 0; i < 2; i++) begin : g_led
      always_ff @(posedge clk_sys_in or posedge rst_in) begin
         if (rst_in) begin
            led_out[i] <= 1'b0;
         end else if (led_en[i]) begin
            led_out[i] <= led_pol[i] ? led_val[i] : ~led_val[i]; // R9
         end else begin
            led_out[i] <= led_pol[i] ? led_source_in[i] : ~led_source_in[i]; // R8
         end
      end
   end

   // wake filter register; the clear bit is not stored
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wake_q <= psl_pkg::WAKE_RESET & ~(16'h0001 << psl_pkg::WK_LVL_CLR);
      end else if (wr_fire && reg_hit(wb_adr_in, psl_pkg::IDX_WAKE)) begin
         wake_q <= (wake_q & ~(psl_pkg::WAKE_WMASK & wmask_lanes)) |
                   (wb_dat_in[15:0] & psl_pkg::WAKE_WMASK & wmask_lanes &
                    ~(16'h0001 << psl_pkg::WK_LVL_CLR));
      end
   end

   assign lvl_clear = wr_fire && reg_hit(wb_adr_in, psl_pkg::IDX_WAKE) && hi_lane &&
                      !wb_dat_in[psl_pkg::WK_LVL_CLR]; // R11

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wake_detect_out <= 1'b1;
         secure_check_out <= 1'b0;
         bit_mask_out <= 1'b0;
      end else begin
         wake_detect_out <= wake_q[psl_pkg::WK_ENABLE]; // R14
         secure_check_out <= wake_q[psl_pkg::WK_SECURE]; // R15
         bit_mask_out <= wake_q[psl_pkg::WK_BIT_MASK];
      end
   end

   // qualification of incoming wake events
   assign crc_ok = !(wake_q[psl_pkg::WK_CRC_GATE] && bad_crc_in); // R10
   assign pkt_ok = wake_packet_in && wake_q[psl_pkg::WK_ENABLE] && crc_ok &&
                   (!wake_q[psl_pkg::WK_SECURE] || password_ok_in); // R14 R15
   assign pat_ok = pattern_match_in && wake_q[psl_pkg::WK_ENABLE] && crc_ok; // R14
   assign wake_event = pkt_ok || pat_ok;
   assign irq_set = {pat_ok, pkt_ok && wake_q[psl_pkg::WK_PKT_EN]}; // R16

   // indication pin; the pulse is stretched to the fast-clock width
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wind_q <= psl_pkg::WI_IDLE;
         pulse_cnt_q <= 4'h0;
      end else begin
         unique case (wind_q)
            psl_pkg::WI_IDLE: begin
               if (wake_event) begin
                  if (wake_q[psl_pkg::WK_IND_SEL]) begin // R13
                     wind_q <= psl_pkg::WI_LEVEL;
                  end else begin
                     wind_q <= psl_pkg::WI_PULSE;
                     pulse_cnt_q <= pulse_len(wake_q[psl_pkg::WK_WIDTH_HI:psl_pkg::WK_WIDTH_LO]); // R12
                  end
               end
            end
            psl_pkg::WI_PULSE: begin
               // events during a pulse are merged into it
               if (pulse_cnt_q == 4'h1) begin
                  wind_q <= psl_pkg::WI_IDLE;
                  pulse_cnt_q <= 4'h0;
               end else begin
                  pulse_cnt_q <= pulse_cnt_q - 4'h1; // R12
               end
            end
            psl_pkg::WI_LEVEL: begin
               if (lvl_clear && !wake_event) begin // R11
                  wind_q <= psl_pkg::WI_IDLE;
               end
            end
            default: begin
               wind_q <= psl_pkg::WI_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wake_pin_out <= 1'b0;
      end else begin
         wake_pin_out <= (wind_q != psl_pkg::WI_IDLE);
      end
   end

   // source follows any write turning wake detection on
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         int_source_q <= 1'b1;
      end else if (wr_fire && reg_hit(wb_adr_in, psl_pkg::IDX_WAKE) && lo_lane &&
                   wb_dat_in[psl_pkg::WK_ENABLE]) begin
         int_source_q <= 1'b1; // R17
      end else if (wr_fire && reg_hit(wb_adr_in, psl_pkg::IDX_INT_SOURCE) && lo_lane) begin
         int_source_q <= wb_dat_in[0];
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wake_int_source_out <= 1'b1;
      end else begin
         wake_int_source_out <= int_source_q; // R17
      end
   end

   // sticky status, a new event beats a simultaneous clear
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         irq_status_q <= '0;
      end else if (wr_fire && reg_hit(wb_adr_in, psl_pkg::IDX_IRQ_STATUS) && lo_lane) begin
         irq_status_q <= (irq_status_q & ~wb_dat_in[IRQ_W-1:0]) | irq_set;
      end else begin
         irq_status_q <= irq_status_q | irq_set;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         irq_mask_q <= '0;
      end else if (wr_fire && reg_hit(wb_adr_in, psl_pkg::IDX_IRQ_MASK) && lo_lane) begin
         irq_mask_q <= wb_dat_in[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_status_q & irq_mask_q);
      end
   end

endmodule

// [test/psl_config_sva.sv]
`timescale 1ns/1ps
module psl_config_sva (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic strap_valid_sel_in,
   input wire logic strap_fast_link_in,
   input wire logic strap_crossover_disable_in,
   input wire logic strap_rmii_mode_in,
   input wire logic strap_rmii_slave_in,
   input wire logic strap_an_hi_in,
   input wire logic strap_an_lo_in,
   input wire logic strap_autoneg_disable_in,
   input wire logic crs_dv_in,
   input wire logic rx_dv_in,
   input wire logic rx_valid_pin_out,
   input wire logic rmii_mode_out,
   input wire logic rmii_slave_out,
   input wire logic [4:0] fld_preset_out,
   input wire logic auto_crossover_out,
   input wire logic [3:0] advert_ability_out,
   input wire logic autoneg_enable_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);
   logic [2:0] age_q;
   logic [7:0] pins_q;
   logic settled;
   // own strap copy, taken while pins still held
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) age_q <= 3'h0;
      else if (age_q != 3'h7) age_q <= age_q + 3'h1;
   end
   always_ff @(posedge clk_sys_in) begin
      if (!rst_in && age_q == 3'h5) begin
         pins_q <= {strap_valid_sel_in, strap_fast_link_in, strap_crossover_disable_in,
            strap_rmii_mode_in, strap_rmii_slave_in, strap_an_hi_in, strap_an_lo_in,
            strap_autoneg_disable_in};
      end
   end
   assign settled = age_q[2] & age_q[1];
   property p_ack;
      wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not a single cycle after request");
   property p_dat;
      wb_dat_out[31:16] == 16'h0 && (wb_ack_out || wb_dat_out == 32'h0);
   endproperty
   a_dat: assert property (p_dat) else $error("read data outside ack window");
   property p_pin;
      settled && $stable(rmii_mode_out) |-> rx_valid_pin_out ==
         ((rmii_mode_out && !pins_q[7]) ? $past(crs_dv_in) : $past(rx_dv_in));
   endproperty
   a_pin: assert property (p_pin) else $error("receive valid pin source wrong");
   property p_fld;
      settled |-> fld_preset_out == (pins_q[6] ? psl_pkg::FLD_ON : psl_pkg::FLD_OFF);
   endproperty
   a_fld: assert property (p_fld) else $error("fast link preset wrong");
   property p_xover;
      settled |-> auto_crossover_out == !pins_q[5];
   endproperty
   a_xover: assert property (p_xover) else $error("crossover not inverted strap");
   property p_role;
      settled |-> rmii_mode_out == pins_q[4] && rmii_slave_out == pins_q[3];
   endproperty
   a_role: assert property (p_role) else $error("interface or clock role wrong");
   property p_advert;
      settled |-> advert_ability_out ==
         (pins_q[2] ? (pins_q[1] ? 4'hF : 4'h5) : (pins_q[1] ? 4'h3 : 4'h1));
   endproperty
   a_advert: assert property (p_advert) else $error("advertised abilities wrong");
   property p_an;
      settled |-> autoneg_enable_out == !pins_q[0];
   endproperty
   a_an: assert property (p_an) else $error("autoneg enable not inverted strap");
   property p_held;
      settled |-> ($stable(fld_preset_out) && $stable(advert_ability_out)) [*2];
   endproperty
   a_held: assert property (p_held) else $error("strap outputs moved");
endmodule
bind psl_config psl_config_sva chk_i (.*);

// [test/psl_mac_model.sv]
`timescale 1ns/1ps
module psl_mac_model (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   output logic crs_dv_out,
   output logic rx_dv_out
);
   logic [3:0] step_q;
   // lines differ often, so a wrong pin choice shows fast
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) step_q <= 4'h0;
      else step_q <= step_q + 4'h1;
   end
   assign crs_dv_out = step_q[0] ^ step_q[2];
   assign rx_dv_out = step_q[1];
endmodule

// [test/test_phy_strap_led_wol_config.sv]
`timescale 1ns/1ps
module test_phy_strap_led_wol_config;
   // strap pins, strap register
   localparam logic [23:0] STRAPS [3] = '{24'h7B011A, 24'h941095, 24'h861087};
   localparam logic [27:0] RESETS [6] = '{{psl_pkg::IDX_LED, 16'h0040},
      {psl_pkg::IDX_WAKE, 16'h1081}, {psl_pkg::IDX_IRQ_STATUS, 16'h0000},
      {psl_pkg::IDX_IRQ_MASK, 16'h0000}, {psl_pkg::IDX_INT_SOURCE, 16'h0001},
      {12'h4FE, 16'h0000}};
   // cfg, source, pins
   localparam logic [19:0] LEDS [7] = '{20'h00006, 20'h00445, 20'h0011F, 20'h00773,
      20'h0033C, 20'h0055C, 20'hFF88C};
   // cfg, {pkt, pat, bad crc, pw ok}, pin cycles, status
   localparam logic [25:0] WAKES [12] = '{{16'h1081, 4'h8, 4'h2, 2'h1},
      {16'h12C1, 4'h8, 4'h3, 2'h1}, {16'h1481, 4'h8, 4'h6, 2'h1},
      {16'h1681, 4'h8, 4'hB, 2'h1}, {16'h1081, 4'hA, 4'h0, 2'h0},
      {16'h0081, 4'hA, 4'h2, 2'h1}, {16'h10A1, 4'h8, 4'h0, 2'h0},
      {16'h10A1, 4'h9, 4'h2, 2'h1}, {16'h1001, 4'h8, 4'h0, 2'h0},
      {16'h1080, 4'h8, 4'h2, 2'h0}, {16'h1080, 4'h4, 4'h2, 2'h2},
      {16'h1081, 4'h6, 4'h0, 2'h0}};
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
   logic [15:0] wb_adr_in = 16'h0000, rd;
   logic [3:0] wb_sel_in = 4'h0;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out;
   logic [7:0] pins = 8'h00;
   logic [1:0] led_source_in = 2'h0, led_out;
   logic wake_packet_in = 1'b0, pattern_match_in = 1'b0, bad_crc_in = 1'b0;
   logic password_ok_in = 1'b0, wb_ack_out, crs_dv_in, rx_dv_in, rx_valid_pin_out;
   logic rmii_mode_out, rmii_slave_out, auto_crossover_out, autoneg_enable_out, irq_out;
   logic wake_detect_out, secure_check_out, bit_mask_out, wake_pin_out, wake_int_source_out;
   logic irq_seen;
   logic [4:0] fld_preset_out;
   logic [3:0] advert_ability_out;
   int num_errors = 0, n_checks = 0, cycles = 0, hi;
   always #25 clk_sys_in = ~clk_sys_in;
   psl_config dut (.clk_sys_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
      .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .strap_valid_sel_in(pins[7]),
      .strap_fast_link_in(pins[6]), .strap_crossover_disable_in(pins[5]),
      .strap_rmii_mode_in(pins[4]), .strap_rmii_slave_in(pins[3]), .strap_an_hi_in(pins[2]),
      .strap_an_lo_in(pins[1]), .strap_autoneg_disable_in(pins[0]), .crs_dv_in, .rx_dv_in,
      .led_source_in, .wake_packet_in, .pattern_match_in, .bad_crc_in, .password_ok_in,
      .rx_valid_pin_out, .rmii_mode_out, .rmii_slave_out, .fld_preset_out,
      .auto_crossover_out, .advert_ability_out, .autoneg_enable_out, .led_out,
      .wake_detect_out, .secure_check_out, .bit_mask_out, .wake_pin_out,
      .wake_int_source_out, .irq_out);
   psl_mac_model mac (.clk_sys_in, .rst_in, .crs_dv_out(crs_dv_in), .rx_dv_out(rx_dv_in));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // entered just after a rising edge; leaves one idle cycle behind
   task automatic wb(input logic [11:0] idx, input logic we, input logic [15:0] dat,
         input logic [3:0] sel);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= we;
      wb_adr_in <= {2'h0, idx, 2'h0};
      wb_sel_in <= sel;
      wb_dat_in <= {16'h0000, dat};
      do @(posedge clk_sys_in); while (wb_ack_out !== 1'b1);
      rd = wb_dat_out[15:0];
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic restart(input logic [7:0] v);
      rst_in <= 1'b1;
      pins <= v;
      repeat (16) @(posedge clk_sys_in);
      chk({7'h00, auto_crossover_out, autoneg_enable_out, wake_detect_out, wake_int_source_out,
         irq_out, advert_ability_out}, 16'h01EF, "reset outputs");
      rst_in <= 1'b0;
      repeat (8) @(posedge clk_sys_in);
   endtask
   task automatic fire(input logic [3:0] ev);
      {wake_packet_in, pattern_match_in, bad_crc_in, password_ok_in} <= ev;
      @(posedge clk_sys_in);
      {wake_packet_in, pattern_match_in, bad_crc_in, password_ok_in} <= 4'h0;
      hi = 0;
      irq_seen = 1'b0;
      repeat (16) begin
         @(posedge clk_sys_in);
         if (wake_pin_out === 1'b1) hi++;
         if (irq_out === 1'b1) irq_seen = 1'b1;
      end
   endtask
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         complete_run();
      end
   end
   initial begin
      for (int i = 0; i < 3; i++) begin
         restart(STRAPS[i][23:16]);
         wb(psl_pkg::IDX_STRAP, 1'b0, 16'h0000, 4'h3);
         chk(rd, STRAPS[i][15:0], "strap reg");
         chk({11'h0, fld_preset_out},
            {11'h0, STRAPS[i][22] ? psl_pkg::FLD_ON : psl_pkg::FLD_OFF}, "fld");
      end
      pins <= ~pins;
      wb(psl_pkg::IDX_STRAP, 1'b0, 16'h0000, 4'h3);
      chk(rd, 16'h1087, "strap moved");
      wb(12'h4FE, 1'b1, 16'hFFFF, 4'hF);
      for (int i = 0; i < 6; i++) begin
         wb(RESETS[i][27:16], 1'b0, 16'h0000, 4'h3);
         chk(rd, RESETS[i][15:0], "reset value");
      end
      for (int i = 0; i < 7; i++) begin
         led_source_in <= LEDS[i][3:2];
         wb(psl_pkg::IDX_LED, 1'b1, LEDS[i][19:4], 4'h1);
         @(posedge clk_sys_in);
         chk({14'h0, led_out}, {14'h0, LEDS[i][1:0]}, "led pins");
         wb(psl_pkg::IDX_LED, 1'b0, 16'h0000, 4'h3);
         chk(rd, LEDS[i][19:4] & psl_pkg::LED_WMASK, "led reg");
      end
      wb(psl_pkg::IDX_IRQ_MASK, 1'b1, 16'h0003, 4'h1);
      for (int i = 0; i < 12; i++) begin
         wb(psl_pkg::IDX_WAKE, 1'b1, WAKES[i][25:10], 4'h3);
         @(posedge clk_sys_in);
         chk({13'h0, wake_detect_out, secure_check_out, bit_mask_out},
            {13'h0, WAKES[i][17], WAKES[i][15], WAKES[i][16]}, "wake cfg");
         fire(WAKES[i][9:6]);
         chk(16'(hi), {12'h0, WAKES[i][5:2]}, "pin cycles");
         chk({15'h0, irq_seen}, {15'h0, |WAKES[i][1:0]}, "irq");
         wb(psl_pkg::IDX_IRQ_STATUS, 1'b0, 16'h0000, 4'h3);
         chk(rd, {14'h0, WAKES[i][1:0]}, "status");
         wb(psl_pkg::IDX_IRQ_STATUS, 1'b1, 16'h0003, 4'h1);
      end
      // masked event: sticky status, but no line
      wb(psl_pkg::IDX_IRQ_MASK, 1'b1, 16'h0000, 4'h1);
      fire(4'h8);
      chk({15'h0, irq_seen}, 16'h0000, "masked irq");
      wb(psl_pkg::IDX_IRQ_STATUS, 1'b0, 16'h0000, 4'h3);
      chk(rd, 16'h0001, "sticky status");
      wb(psl_pkg::IDX_IRQ_STATUS, 1'b1, 16'h0003, 4'h1);
      wb(psl_pkg::IDX_IRQ_STATUS, 1'b0, 16'h0000, 4'h3);
      chk(rd, 16'h0000, "status cleared");
      wb(psl_pkg::IDX_WAKE, 1'b1, 16'h1181, 4'h3);
      fire(4'h8);
      chk({15'h0, wake_pin_out}, 16'h0001, "level held");
      wb(psl_pkg::IDX_WAKE, 1'b1, 16'h1981, 4'h3);
      chk({15'h0, wake_pin_out}, 16'h0001, "level kept");
      wb(psl_pkg::IDX_WAKE, 1'b0, 16'h0000, 4'h3);
      chk(rd, 16'h1981, "level bit");
      wb(psl_pkg::IDX_WAKE, 1'b1, 16'h1181, 4'h3);
      @(posedge clk_sys_in);
      chk({15'h0, wake_pin_out}, 16'h0000, "level clear");
      wb(psl_pkg::IDX_INT_SOURCE, 1'b1, 16'h0000, 4'h1);
      @(posedge clk_sys_in);
      chk({15'h0, wake_int_source_out}, 16'h0000, "source low");
      wb(psl_pkg::IDX_WAKE, 1'b1, 16'h1081, 4'h3);
      @(posedge clk_sys_in);
      chk({15'h0, wake_int_source_out}, 16'h0001, "source forced");
      complete_run();
   end
endmodule
